// file: design/dtcc_pkg.sv
package dtcc_pkg;
  localparam int          CNT_W          = 16;
  localparam int          NUM_SUB        = 6;
  localparam int          NUM_WAVE       = 4;
  localparam int          NUM_FILT       = 10;
  localparam int          DIV_W          = 9;
  localparam int          SUB_LO_CH      = 0;
  localparam int          SUB_HI_CH      = 5;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CCR_RESET      = 16'h0000;
  localparam int          BASE_DIV2_SH   = 1;
  localparam int          BASE_DIV4_SH   = 2;
  localparam logic [2:0]  PRE_SEL_MAX    = 3'h6;
  localparam int          FXX_HZ_DEF     = 100_000_000;
  localparam int          BASE_MAX_HZ    = 16_000_000;
  localparam int          COUNT_MAX_HZ   = 8_000_000;
  localparam int          FILT_PIN_CLK   = 0;
  localparam int          FILT_PIN_CAP   = 1;
  localparam int          FILT_PIN_CTL   = 7;
  localparam int          FILT_PIN_UPS   = 8;
  localparam int          DLY_DEPTH      = 4;

  // Software configuration bits, held steady by the owner
  typedef struct packed {
    logic       base_div4;
    logic [2:0] pre_sel;
    logic       ext_clk_en;
    logic       ext_gate_en;
    logic       ext_clear_en;
    logic       ext_dir_en;
    logic       count_down;
    logic       cascade;
    logic       delay_en;
    logic       filt_en;
    logic [5:0] cap_mode;
    logic [5:0] ups_sel;
  } dtcc_cfg_t;
endpackage : dtcc_pkg

// file: design/dtcc_top.sv
`timescale 1ns/1ps
module dtcc_top #(
  parameter int FXX_HZ = dtcc_pkg::FXX_HZ_DEF,
  parameter int CNT_W  = dtcc_pkg::CNT_W
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire dtcc_pkg::dtcc_cfg_t  cfg,
  input  wire logic                 count_run,
  input  wire logic [5:0]           sw_capture,
  input  wire logic [5:0]           ccr_wr,
  input  wire logic [15:0]          ccr_wdata,
  input  wire logic [5:0]           capture_event_pins,
  input  wire logic                 upstream_timer_match_irq_0,
  input  wire logic                 upstream_timer_match_irq_1,
  input  wire logic                 external_count_clock_pin,
  input  wire logic                 external_control_pin,
  output logic [15:0]               timer_a_counter,
  output logic [15:0]               timer_b_counter,
  output logic [5:0][15:0]          subchannel_capture_compare_reg,
  output logic [4:1][15:0]          subchannel_secondary_capture_reg,
  output logic [5:0]                subchannel_match_irq,
  output logic                      counter_a_overflow_irq,
  output logic                      counter_b_overflow_irq,
  output logic [3:0]                waveform_outputs,
  output logic                      a_max,
  output logic                      a_zero,
  output logic                      b_max,
  output logic                      b_zero,
  output logic                      cfg_error,
  output logic                      rate_error
);

  if (CNT_W != dtcc_pkg::CNT_W) begin : g_bad_width
    $error("dtcc_top: counter width must be 16");
  end

  // Input filter: a new level passes only after two equal samples
  logic [dtcc_pkg::NUM_FILT-1:0] raw_in;
  logic [dtcc_pkg::NUM_FILT-1:0] samp;
  logic [dtcc_pkg::NUM_FILT-1:0] filt;
  logic [dtcc_pkg::NUM_FILT-1:0] filt_q;
  logic [dtcc_pkg::NUM_FILT-1:0] rise;
  assign raw_in = {upstream_timer_match_irq_1, upstream_timer_match_irq_0,
                   external_control_pin, capture_event_pins, external_count_clock_pin};

  for (genvar i = 0; i < dtcc_pkg::NUM_FILT; i++) begin : g_filt
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        samp[i] <= 1'b0;
        filt[i] <= 1'b0;
      end else begin
        samp[i] <= raw_in[i];
        if (!cfg.filt_en || samp[i] == raw_in[i]) begin
          filt[i] <= raw_in[i];
        end
      end
    end
  end

  // Edge detection on the filtered inputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt;
    end
  end
  assign rise = filt & ~filt_q;

  // Free divider; count tick when the low shift bits are all ones
  logic [dtcc_pkg::DIV_W-1:0] div_cnt;
  logic [3:0]                 shift;
  logic [dtcc_pkg::DIV_W-1:0] div_mask;
  logic                       pre_tick;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign shift    = 4'(cfg.base_div4 ? dtcc_pkg::BASE_DIV4_SH : dtcc_pkg::BASE_DIV2_SH)
                  + 4'(cfg.pre_sel) + 4'h1;
  assign div_mask = dtcc_pkg::DIV_W'((1 << shift) - 1);
  assign pre_tick = (div_cnt & div_mask) == div_mask;

  // Rate limits for the chosen base and count clocks
  always_comb begin
    int base_hz;
    int cnt_hz;
    base_hz = FXX_HZ >> (cfg.base_div4 ? dtcc_pkg::BASE_DIV4_SH : dtcc_pkg::BASE_DIV2_SH);
    cnt_hz  = FXX_HZ >> shift;
    rate_error = !cfg.ext_clk_en && (base_hz > dtcc_pkg::BASE_MAX_HZ
                 || cnt_hz > dtcc_pkg::COUNT_MAX_HZ);
  end

  // Illegal external-control combinations stop the counters
  assign cfg_error = (cfg.ext_gate_en && cfg.ext_clear_en && cfg.ext_dir_en)
                   || cfg.pre_sel > dtcc_pkg::PRE_SEL_MAX;

  // Count step, clear and direction
  logic ctl_lvl;
  logic tick;
  logic step;
  logic ext_clr;
  logic dir_down;
  assign ctl_lvl  = filt[dtcc_pkg::FILT_PIN_CTL];
  assign tick     = cfg.ext_clk_en ? rise[dtcc_pkg::FILT_PIN_CLK] : pre_tick;
  assign step     = tick && count_run && !cfg_error
                  && (!cfg.ext_gate_en || ctl_lvl);
  assign ext_clr  = cfg.ext_clear_en && !cfg.cascade && !cfg_error
                  && rise[dtcc_pkg::FILT_PIN_CTL];
  assign dir_down = !cfg.cascade
                  && (cfg.ext_dir_en ? !ctl_lvl : cfg.count_down);

  logic        cascade_count_pulse_pulse;
  logic        step_b;
  logic [15:0] next_a;
  logic [15:0] next_b;
  assign cascade_count_pulse_pulse = step && a_max;
  assign step_b     = cfg.cascade ? cascade_count_pulse_pulse : step;
  assign next_a     = dir_down ? timer_a_counter - 1'b1 : timer_a_counter + 1'b1;
  assign next_b     = dir_down ? timer_b_counter - 1'b1 : timer_b_counter + 1'b1;

  // Counter A, the low half in cascade
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_a_counter <= dtcc_pkg::CNT_ZERO;
    end else if (ext_clr) begin
      timer_a_counter <= dtcc_pkg::CNT_ZERO;
    end else if (step) begin
      timer_a_counter <= next_a;
    end
  end

  // Counter B, the high half in cascade
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_b_counter <= dtcc_pkg::CNT_ZERO;
    end else if (ext_clr) begin
      timer_b_counter <= dtcc_pkg::CNT_ZERO;
    end else if (step_b) begin
      timer_b_counter <= next_b;
    end
  end

  assign a_max  = timer_a_counter == dtcc_pkg::CNT_MAX;
  assign a_zero = timer_a_counter == dtcc_pkg::CNT_ZERO;
  assign b_max  = timer_b_counter == dtcc_pkg::CNT_MAX;
  assign b_zero = timer_b_counter == dtcc_pkg::CNT_ZERO;

  // Overflow pulses when a counter moves onto FFFFH
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_a_overflow_irq <= 1'b0;
      counter_b_overflow_irq <= 1'b0;
    end else begin
      counter_a_overflow_irq <= step && !ext_clr && next_a == dtcc_pkg::CNT_MAX;
      counter_b_overflow_irq <= step_b && !ext_clr && next_b == dtcc_pkg::CNT_MAX;
    end
  end

  // Channel usability: cascade keeps only 1 to 4, capture only
  function automatic logic dtcc_usable(input int ch, input logic cascade_count_pulse);
    return !cascade_count_pulse || (ch != dtcc_pkg::SUB_LO_CH && ch != dtcc_pkg::SUB_HI_CH);
  endfunction : dtcc_usable

  // Capture and compare channels
  logic [5:0] cap_trig;
  logic [5:0] cap_en;
  logic [5:0] cmp_hit;
  for (genvar n = 0; n < dtcc_pkg::NUM_SUB; n++) begin : g_sub
    logic        ups;
    logic        is_cap;
    logic [15:0] own_cnt;
    logic [15:0] own_next;
    logic        own_step;
    assign ups      = n % 2 == 0 ? filt[dtcc_pkg::FILT_PIN_UPS]
                                 : filt[dtcc_pkg::FILT_PIN_UPS + 1];
    assign is_cap   = cfg.cap_mode[n] || cfg.cascade;
    assign own_cnt  = n == dtcc_pkg::SUB_HI_CH ? timer_b_counter : timer_a_counter;
    assign own_next = n == dtcc_pkg::SUB_HI_CH ? next_b : next_a;
    assign own_step = n == dtcc_pkg::SUB_HI_CH ? step_b : step;
    assign cap_trig[n] = rise[dtcc_pkg::FILT_PIN_CAP + n] || sw_capture[n]
                       || (cfg.ups_sel[n] && ups && !filt_q[dtcc_pkg::FILT_PIN_UPS + n % 2]);
    assign cap_en[n]   = is_cap && cap_trig[n] && dtcc_usable(n, cfg.cascade);
    assign cmp_hit[n]  = !is_cap && own_step && !ext_clr
                       && own_next == subchannel_capture_compare_reg[n];

    // Capture wins over a software write in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        subchannel_capture_compare_reg[n] <= dtcc_pkg::CCR_RESET;
      end else if (cap_en[n]) begin
        subchannel_capture_compare_reg[n] <= own_cnt;
      end else if (ccr_wr[n]) begin
        subchannel_capture_compare_reg[n] <= ccr_wdata;
      end
    end

    // Match pulse on compare, or capture pulse in capture mode
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        subchannel_match_irq[n] <= 1'b0;
      end else begin
        subchannel_match_irq[n] <= cmp_hit[n] || cap_en[n];
      end
    end

    // Channels 1 to 4 also latch counter B for the high half
    if (n >= 1 && n <= dtcc_pkg::NUM_WAVE) begin : g_sec
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          subchannel_secondary_capture_reg[n] <= dtcc_pkg::CCR_RESET;
        end else if (cap_en[n]) begin
          subchannel_secondary_capture_reg[n] <= timer_b_counter;
        end
      end
    end
  end

  // Waveform outputs: set by match, reset when counter A reaches zero
  logic [3:0]                      wave_raw;
  logic [dtcc_pkg::DLY_DEPTH-1:0]  dly [4];
  for (genvar w = 0; w < dtcc_pkg::NUM_WAVE; w++) begin : g_wave
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        wave_raw[w] <= 1'b0;
      end else if (cmp_hit[w + 1]) begin
        wave_raw[w] <= 1'b1;
      end else if (a_zero) begin
        wave_raw[w] <= 1'b0;
      end
    end

    // Output w lags by w clocks so edges never coincide
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        dly[w]              <= '0;
        waveform_outputs[w] <= 1'b0;
      end else begin
        dly[w]              <= {dly[w][dtcc_pkg::DLY_DEPTH-2:0], wave_raw[w]};
        waveform_outputs[w] <= (cfg.delay_en && w > 0) ? dly[w][(w > 0) ? w - 1 : 0]
                                                       : wave_raw[w];
      end
    end
  end

  // Checks
  a_wrap_up: assert property (@(posedge clk) disable iff (!arst_n)
    (step && !ext_clr && !dir_down && a_max) |=> a_zero)
    else $error("counter A did not wrap to zero");

  a_ovf_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    counter_a_overflow_irq |-> a_max && $changed(timer_a_counter))
    else $error("overflow pulse without reaching maximum");

  a_cascade_count_pulse_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.cascade && !a_max && !ext_clr) |=> $stable(timer_b_counter))
    else $error("counter B moved in cascade without carry");

  a_cascade_count_pulse_noclr: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.cascade |-> !ext_clr)
    else $error("pin clear acted in cascade");

  a_gate_off: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.ext_gate_en && !ctl_lvl && !ext_clr) |=> $stable(timer_a_counter))
    else $error("counter moved while gated off");

  a_combo_stop: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.ext_gate_en && cfg.ext_clear_en && cfg.ext_dir_en) |=> $stable(timer_a_counter))
    else $error("counter ran with all pin controls set");

  a_match_irq: assert property (@(posedge clk) disable iff (!arst_n)
    (!cfg.cascade && !cfg.cap_mode[0] && step && !ext_clr
     && next_a == subchannel_capture_compare_reg[0]) |=> subchannel_match_irq[0])
    else $error("missed compare match on channel 0");

  a_cap_value: assert property (@(posedge clk) disable iff (!arst_n)
    cap_en[1] |=> subchannel_capture_compare_reg[1] == $past(timer_a_counter)
                  && subchannel_secondary_capture_reg[1] == $past(timer_b_counter))
    else $error("capture latched wrong value");

  a_wave_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (a_zero && !cmp_hit[1]) ##1 !cfg.delay_en |=> !waveform_outputs[0])
    else $error("zero count did not reset output");

  a_wave_delay: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg.delay_en && $rose(wave_raw[3])) ##1 cfg.delay_en[*3] |=> $rose(waveform_outputs[3]))
    else $error("output 4 delay wrong");

endmodule : dtcc_top

// file: test/dtcc_pin_model.sv
`timescale 1ns/1ps
// Far-side pins: count clock, control pin, capture pins and upstream match lines
module dtcc_pin_model (
  input  wire logic  clk,
  output logic       external_count_clock_pin,
  output logic       external_control_pin,
  output logic [5:0] capture_event_pins,
  output logic       upstream_timer_match_irq_0,
  output logic       upstream_timer_match_irq_1
);
  // All pins idle low; the count clock stands still between bursts
  initial begin
    external_count_clock_pin   = 1'b0;
    external_control_pin       = 1'b0;
    capture_event_pins         = 6'h00;
    upstream_timer_match_irq_0 = 1'b0;
    upstream_timer_match_irq_1 = 1'b0;
  end

  // Count clock burst; 4 cycles per phase outlast the input filter
  task automatic clock_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      external_count_clock_pin = 1'b1;
      repeat (4) @(negedge clk);
      external_count_clock_pin = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask : clock_pulses

  // Control pin level, then let filter and edge logic settle
  task automatic control_level(input logic v);
    external_control_pin = v;
    repeat (6) @(negedge clk);
  endtask : control_level

  // One rising edge on a capture pin (ch 0..5) or upstream line (ch 6, 7)
  task automatic event_edge(input int ch);
    if (ch < 6) capture_event_pins[ch] = 1'b1;
    else if (ch == 6) upstream_timer_match_irq_0 = 1'b1;
    else upstream_timer_match_irq_1 = 1'b1;
    repeat (4) @(negedge clk);
    capture_event_pins         = 6'h00;
    upstream_timer_match_irq_0 = 1'b0;
    upstream_timer_match_irq_1 = 1'b0;
    repeat (6) @(negedge clk);
  endtask : event_edge
endmodule : dtcc_pin_model

// file: test/test_dual_timer_capture_compare.sv
`timescale 1ns/1ps
module test_dual_timer_capture_compare;
  typedef struct packed {
    logic [7:0]  ev;
    logic [2:0]  ch;
    logic        has_val;
    logic [15:0] val;
  } dtcc_note_t;

  logic clk, arst_n, count_run, ecp, ctl, up0, up1, a_max, a_zero, b_max, b_zero;
  logic cfg_error, rate_error, ovf_a, ovf_b;
  dtcc_pkg::dtcc_cfg_t cfg, next_cfg;
  logic [5:0] sw_capture, ccr_wr, cap_pins, irq;
  logic [15:0] ccr_wdata, ta, tb, av;
  logic [5:0][15:0] ccr;
  logic [4:1][15:0] sec;
  logic [3:0] wave;
  logic [7:0] ev;
  logic [31:0] lfsr;
  dtcc_note_t notes[$];
  dtcc_note_t nt;
  int bad_count, n_tests;

  dtcc_top i_dut (.clk(clk), .arst_n(arst_n), .cfg(cfg), .count_run(count_run),
    .sw_capture(sw_capture), .ccr_wr(ccr_wr), .ccr_wdata(ccr_wdata),
    .capture_event_pins(cap_pins), .upstream_timer_match_irq_0(up0),
    .upstream_timer_match_irq_1(up1), .external_count_clock_pin(ecp),
    .external_control_pin(ctl), .timer_a_counter(ta), .timer_b_counter(tb),
    .subchannel_capture_compare_reg(ccr), .subchannel_secondary_capture_reg(sec),
    .subchannel_match_irq(irq), .counter_a_overflow_irq(ovf_a),
    .counter_b_overflow_irq(ovf_b), .waveform_outputs(wave), .a_max(a_max),
    .a_zero(a_zero), .b_max(b_max), .b_zero(b_zero), .cfg_error(cfg_error),
    .rate_error(rate_error));

  dtcc_pin_model i_pins (.clk(clk), .external_count_clock_pin(ecp),
    .external_control_pin(ctl), .capture_event_pins(cap_pins),
    .upstream_timer_match_irq_0(up0), .upstream_timer_match_irq_1(up1));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : check

  task automatic note(input logic [7:0] e, input int ch, input logic hv, input logic [15:0] v);
    notes.push_back('{e, ch[2:0], hv, v});
  endtask : note

  task automatic pulses(input int n);
    i_pins.clock_pulses(n);
    repeat (6) @(negedge clk);
  endtask : pulses

  task automatic wr_ccr(input int ch, input logic [15:0] v);
    ccr_wr[ch] = 1'b1;
    ccr_wdata  = v;
    @(negedge clk);
    ccr_wr = 6'h00;
    @(negedge clk);
  endtask : wr_ccr

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Every interrupt pulse takes the oldest note and is compared with it
  always @(negedge clk) begin
    ev = {ovf_b, ovf_a, irq};
    if (arst_n && ev !== 8'h00) begin
      if (notes.size() == 0) check(ev, 8'h00);
      else begin
        nt = notes.pop_front();
        check(ev, nt.ev);
        if (nt.has_val) check(ccr[nt.ch], nt.val);
      end
    end
  end

  // Watchdog well beyond the expected 1500 or so cycles
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // Main sequence, inputs change on the falling edge
  initial begin
    clk = 0; arst_n = 0; cfg = '0; count_run = 0; sw_capture = 0;
    ccr_wr = 0; ccr_wdata = 0; lfsr = 32'hC623;
    repeat (16) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    check({ta, tb}, 32'h0);
    check({a_zero, b_zero, a_max, b_max}, 4'hC);
    check(rate_error, 1'b1);
    for (int c = 0; c < 6; c++) wr_ccr(c, 16'h8000);
    done("reset");
    // Base /2, prescale /2: one tick each 4 clocks
    cfg.ext_clear_en = 1'b1;
    count_run = 1'b1;
    repeat (64) @(negedge clk);
    count_run = 1'b0;
    check(ta >= 16'hF && ta <= 16'h11, 1'b1);
    i_pins.control_level(1'b1);
    i_pins.control_level(1'b0);
    check(ta, 16'h0);
    // Base /4, prescale /128: one tick each 512 clocks
    cfg.base_div4 = 1'b1;
    cfg.pre_sel = 3'h6;
    count_run = 1'b1;
    repeat (1030) @(negedge clk);
    check(ta >= 16'h2 && ta <= 16'h3, 1'b1);
    i_pins.control_level(1'b1);
    next_cfg = '0;
    next_cfg.ext_clk_en = 1'b1;
    next_cfg.filt_en = 1'b1;
    next_cfg.cap_mode = 6'h0C;
    next_cfg.ups_sel = 6'h0C;
    cfg = next_cfg;
    i_pins.control_level(1'b0);
    done("prescaler");
    // External clock, compare matches and waveform set
    wr_ccr(0, 16'h3);
    wr_ccr(1, 16'h2);
    note(8'h02, 1, 0, 0);
    note(8'h01, 0, 0, 0);
    pulses(3);
    check(ta, 16'h3);
    check(wave, 4'h1);
    lfsr = lfsr_next(lfsr);
    av = 16'h3 + 16'(lfsr[1:0]) + 16'h1;
    pulses(int'(av) - 3);
    // Three capture sources on channel 2, then two on channel 3
    note(8'h04, 2, 1, av);
    sw_capture[2] = 1'b1;
    @(negedge clk);
    sw_capture = 6'h00;
    repeat (4) @(negedge clk);
    note(8'h04, 2, 1, av);
    i_pins.event_edge(2);
    note(8'h04, 2, 1, av);
    i_pins.event_edge(6);
    note(8'h08, 3, 1, av);
    i_pins.event_edge(7);
    note(8'h08, 3, 1, av);
    i_pins.event_edge(3);
    done("capture");
    // Gate, direction and refused combination
    cfg.ext_gate_en = 1'b1;
    pulses(2);
    check(ta, av);
    i_pins.control_level(1'b1);
    pulses(1);
    check(ta, av + 16'h1);
    cfg.ext_gate_en = 1'b0;
    cfg.ext_dir_en = 1'b1;
    i_pins.control_level(1'b0);
    pulses(1);
    check(ta, av);
    cfg.ext_gate_en = 1'b1;
    cfg.ext_clear_en = 1'b1;
    pulses(1);
    check({cfg_error, ta}, {1'b1, av});
    cfg.ext_gate_en = 1'b0;
    cfg.ext_dir_en = 1'b0;
    i_pins.control_level(1'b1);
    i_pins.control_level(1'b0);
    check({wave, ta}, 20'h0);
    done("pin modes");
    // Staggered waveform edges: all four channels match on one count
    cfg.cap_mode = 6'h00;
    cfg.delay_en = 1'b1;
    for (int c = 1; c < 5; c++) wr_ccr(c, 16'h1);
    note(8'h1E, 0, 0, 0);
    fork
      i_pins.clock_pulses(1);
      begin
        repeat (4) @(negedge clk);
        for (int k = 1; k < 5; k++) begin
          check(wave, (32'h1 << k) - 32'h1);
          @(negedge clk);
        end
      end
    join
    repeat (6) @(negedge clk);
    i_pins.control_level(1'b1);
    i_pins.control_level(1'b0);
    check({wave, ta}, 20'h0);
    done("delay");
    // Down onto FFFF, then cascade wrap into B
    cfg.count_down = 1'b1;
    note(8'hC0, 0, 0, 0);
    pulses(1);
    check({a_max, ta}, 17'h1FFFF);
    check(tb, 16'hFFFF);
    cfg.count_down = 1'b0;
    cfg.cascade = 1'b1;
    note(8'h02, 1, 1, 16'hFFFF);
    sw_capture = 6'h02;
    @(negedge clk);
    sw_capture = 6'h00;
    repeat (4) @(negedge clk);
    check(sec[1], 16'hFFFF);
    pulses(1);
    check({tb, ta}, 32'h0000_0000);
    pulses(1);
    i_pins.control_level(1'b1);
    check(ta, 16'h1);
    cfg.ext_clear_en = 1'b0;
    cfg.ext_dir_en = 1'b1;
    i_pins.control_level(1'b0);
    pulses(1);
    check({tb, ta}, 32'h0000_0002);
    note(8'h02, 1, 1, 16'h2);
    sw_capture = 6'h03;
    @(negedge clk);
    sw_capture = 6'h00;
    repeat (4) @(negedge clk);
    check(sec[1], 16'h0);
    check(notes.size(), 0);
    done("cascade");
    print_verdict();
  end
endmodule : test_dual_timer_capture_compare
